// ===== design/opt_bit_sync.sv
// two flip-flop synchroniser for a group of slow static bits
`timescale 1ns/1ps
module opt_bit_sync
#(
    parameter int W = 8
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // bits in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] stab_q;
    logic [W-1:0] stab_d;

    // a group without bits has nothing to carry
    if (W < 1)
    begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    // two stages per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                meta_d[i] = async_in[i];
                stab_d[i] = meta_q[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            stab_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync_out = stab_q;

endmodule

// ===== design/opt_cfg_pkg.sv
// constants and types shared by the option byte configuration decoder
// Functional notes
// - delay bit picks 4096 or 256 cycles
// - range field acts only with RC off
// - codes 0-3 resonator ranges, top set other
// - bit 3 low turns RC oscillator on
// - bit 2 low enables PLL halving
// - bit 1 picks times four or eight
// - bit 0 low enables PLL, else bypass
// - package field 00/01/1x gives 32/44/48 pins
// - bit 5 low enables triple slave
package opt_cfg_pkg;

    // stabilization delay lengths in cpu (= pclk) cycles
    localparam int unsigned DLY_LONG_CYC  = 4096;
    localparam int unsigned DLY_SHORT_CYC = 256;
    localparam int unsigned DLY_CNT_W     = 13;
    // edges to wait after reset release before sampling the synchronised bytes
    localparam logic [1:0]  SETTLE_CYC    = 2'h3;

    // option byte 1 bit positions
    localparam int B1_RST_DELAY = 7;
    localparam int B1_RANGE_LO  = 4;
    localparam int B1_RC_OFF    = 3;
    localparam int B1_HALVE     = 2;
    localparam int B1_FACTOR    = 1;
    localparam int B1_BYPASS    = 0;
    // option byte 3 bit positions
    localparam int B3_PKG_LO    = 6;
    localparam int B3_TRIPLE    = 5;
    localparam logic [4:0] B3_RSVD_ONES = 5'h1F;
    localparam logic [7:0] B2_RSVD_ONES = 8'hFF;

    // reset values of the captured option bytes (erased state, except bit 3 of byte 1 low)
    localparam logic [7:0] OPT1_RST = 8'hF7;
    localparam logic [7:0] OPT2_RST = 8'hFF;
    localparam logic [7:0] OPT3_RST = 8'hFF;

    // oscillator range codes
    localparam logic [2:0] RANGE_LP = 3'h0;
    localparam logic [2:0] RANGE_MP = 3'h1;
    localparam logic [2:0] RANGE_MS = 3'h2;
    localparam logic [2:0] RANGE_HS = 3'h3;

    // apb register byte offsets
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0] REG_RAW    = 8'h00;
    localparam logic [7:0] REG_DECODE = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;

    // control register: bit 0 starts the halt exit delay (self clearing)
    localparam int CTRL_HALT_EXIT = 0;

    // status register fields
    localparam int ST_BUSY       = 0;
    localparam int ST_LOADED     = 1;
    localparam int ST_HALVE_BAD  = 2;
    localparam int ST_RSVD_BAD   = 3;

    // loader states
    typedef enum logic [2:0] {
        LD_SETTLE = 3'b001,
        LD_STAB   = 3'b010,
        LD_RUN    = 3'b100
    } load_state_t;

endpackage

// ===== design/option_byte_clock_config.sv
// option byte decoder: captures bytes 1..3 after reset, decodes clock config, apb view
`timescale 1ns/1ps
module option_byte_clock_config
    import opt_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // option bytes from the non-volatile array
    input  wire logic [7:0]        opt_byte1,
    input  wire logic [7:0]        opt_byte2,
    input  wire logic [7:0]        opt_byte3,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // decoded configuration
    output logic                   cpu_hold,
    output logic                   config_valid,
    output logic                   long_reset_delay,
    output logic                   rc_osc_enable,
    output logic      [2:0]        osc_current_range,
    output logic                   range_low_power,
    output logic                   range_medium_power,
    output logic                   range_medium_speed,
    output logic                   range_high_speed,
    output logic                   ext_clock_select,
    output logic                   pll_enable,
    output logic                   pll_factor_eight,
    output logic                   pll_halving_enable,
    output logic                   package_32,
    output logic                   package_44,
    output logic                   package_48,
    output logic                   triple_slave_enable
);

    // synchronised option bytes
    logic [7:0]  b1_s;
    logic [7:0]  b2_s;
    logic [7:0]  b3_s;

    opt_bit_sync #(.W(24)) u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({opt_byte3, opt_byte2, opt_byte1}),
        .sync_out ({b3_s, b2_s, b1_s})
    );

    // loader state
    load_state_t state_q;
    load_state_t state_d;
    logic [1:0]  settle_q;
    logic [1:0]  settle_d;
    logic        capture;
    logic        dly_start;
    logic        dly_long;
    logic        dly_busy;
    logic        dly_done;
    logic        halt_req;

    // captured raw bytes
    logic [7:0]  raw1_q, raw1_d;
    logic [7:0]  raw2_q, raw2_d;
    logic [7:0]  raw3_q, raw3_d;

    // decoded configuration registers
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] dec;
    logic        halve_bad_q, halve_bad_d;
    logic        rsvd_bad_q, rsvd_bad_d;
    logic        hold_q, hold_d;
    logic        valid_q, valid_d;
    logic        triple_q, triple_d;

    // apb response registers
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] rd_mux;
    logic        addr_hit;

    // decode of the synchronised bytes, loaded only at capture
    always_comb
    begin
        dec = '0;
        dec[0] = ~b1_s[B1_RST_DELAY];
        dec[1] = ~b1_s[B1_RC_OFF];
        dec[4:2] = b1_s[B1_RANGE_LO +: 3];
        if (b1_s[B1_RC_OFF])
        begin
            dec[5] = (b1_s[B1_RANGE_LO +: 3] == RANGE_LP);
            dec[6] = (b1_s[B1_RANGE_LO +: 3] == RANGE_MP);
            dec[7] = (b1_s[B1_RANGE_LO +: 3] == RANGE_MS);
            dec[8] = (b1_s[B1_RANGE_LO +: 3] == RANGE_HS);
            dec[9] = b1_s[B1_RANGE_LO + 2] & b1_s[B1_RANGE_LO + 1];
        end
        dec[10] = ~b1_s[B1_BYPASS];
        dec[11] = b1_s[B1_FACTOR];
        dec[12] = ~b1_s[B1_HALVE];
        dec[15] = b3_s[B3_PKG_LO + 1];
        dec[14] = ~b3_s[B3_PKG_LO + 1] & b3_s[B3_PKG_LO];
        dec[13] = ~b3_s[B3_PKG_LO + 1] & ~b3_s[B3_PKG_LO];
    end

    // loader sequence: settle, capture, stabilization delay, run
    always_comb
    begin
        state_d   = state_q;
        settle_d  = settle_q;
        capture   = 1'b0;
        dly_start = 1'b0;
        dly_long  = cfg_q[0];
        unique case (state_q)
            LD_SETTLE:
            begin
                settle_d = settle_q + 1'b1;
                if (settle_q == SETTLE_CYC)
                begin
                    capture   = 1'b1;
                    dly_start = 1'b1;
                    dly_long  = dec[0];
                    state_d   = LD_STAB;
                end
            end
            LD_STAB:
            begin
                if (dly_done)
                begin
                    state_d = LD_RUN;
                end
            end
            LD_RUN:
            begin
                if (halt_req)
                begin
                    dly_start = 1'b1;
                    state_d   = LD_STAB;
                end
            end
            default:
            begin
                state_d = LD_SETTLE;
            end
        endcase
    end

    stab_delay_counter u_delay
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (dly_start),
        .long_sel (dly_long),
        .busy     (dly_busy),
        .done     (dly_done)
    );

    // configuration registers hold from capture until the next reset
    always_comb
    begin
        raw1_d      = raw1_q;
        raw2_d      = raw2_q;
        raw3_d      = raw3_q;
        cfg_d       = cfg_q;
        halve_bad_d = halve_bad_q;
        rsvd_bad_d  = rsvd_bad_q;
        triple_d    = triple_q;
        if (capture)
        begin
            raw1_d = b1_s;
            raw2_d = b2_s;
            raw3_d = b3_s;
            cfg_d  = dec;
            triple_d = ~b3_s[B3_TRIPLE];
            halve_bad_d = ~b1_s[B1_HALVE] & ~b1_s[B1_FACTOR] & ~b1_s[B1_BYPASS];
            rsvd_bad_d = (b2_s != B2_RSVD_ONES) || (b3_s[4:0] != B3_RSVD_ONES);
        end
        // cpu held from reset until the first delay finishes, and on halt exit
        hold_d  = (state_d != LD_RUN);
        valid_d = valid_q | capture;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= LD_SETTLE;
            settle_q    <= '0;
            raw1_q      <= OPT1_RST;
            raw2_q      <= OPT2_RST;
            raw3_q      <= OPT3_RST;
            cfg_q       <= '0;
            halve_bad_q <= 1'b0;
            rsvd_bad_q  <= 1'b0;
            hold_q      <= 1'b1;
            valid_q     <= 1'b0;
            triple_q    <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            settle_q    <= settle_d;
            raw1_q      <= raw1_d;
            raw2_q      <= raw2_d;
            raw3_q      <= raw3_d;
            cfg_q       <= cfg_d;
            halve_bad_q <= halve_bad_d;
            rsvd_bad_q  <= rsvd_bad_d;
            hold_q      <= hold_d;
            valid_q     <= valid_d;
            triple_q    <= triple_d;
        end
    end

    // apb read mux and address decode
    always_comb
    begin
        rd_mux   = '0;
        addr_hit = 1'b1;
        unique case (paddr)
            REG_RAW:    rd_mux = {8'h00, raw3_q, raw2_q, raw1_q};
            REG_DECODE: rd_mux = {16'h0000, cfg_q};
            REG_CTRL:   rd_mux = '0; // trigger only, reads zero
            REG_STATUS:
            begin
                rd_mux[ST_BUSY]      = dly_busy;
                rd_mux[ST_LOADED]    = valid_q;
                rd_mux[ST_HALVE_BAD] = halve_bad_q;
                rd_mux[ST_RSVD_BAD]  = rsvd_bad_q;
            end
            default:    addr_hit = 1'b0;
        endcase
    end

    // one wait state: pready rises one cycle into the access phase,
    // so read data and response come straight from flops
    always_comb
    begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        halt_req  = 1'b0;
        if (psel && penable && !pready_q)
        begin
            pready_d  = 1'b1;
            pslverr_d = ~addr_hit;
            prdata_d  = (addr_hit && !pwrite) ? rd_mux : '0;
        end
        // write takes effect on the completing edge; ignored before run
        if (psel && penable && pready_q && pwrite && addr_hit &&
            paddr == REG_CTRL && pwdata[CTRL_HALT_EXIT] && state_q == LD_RUN)
        begin
            halt_req = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // outputs
    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign cpu_hold            = hold_q;
    assign config_valid        = valid_q;
    assign long_reset_delay    = cfg_q[0];
    assign rc_osc_enable       = cfg_q[1];
    assign osc_current_range   = cfg_q[4:2];
    assign range_low_power     = cfg_q[5];
    assign range_medium_power  = cfg_q[6];
    assign range_medium_speed  = cfg_q[7];
    assign range_high_speed    = cfg_q[8];
    assign ext_clock_select    = cfg_q[9];
    assign pll_enable          = cfg_q[10];
    assign pll_factor_eight    = cfg_q[11];
    assign pll_halving_enable  = cfg_q[12];
    assign package_32          = cfg_q[13];
    assign package_44          = cfg_q[14];
    assign package_48          = cfg_q[15];
    assign triple_slave_enable = triple_q; // zero until capture, like the other decoded outputs

endmodule

// ===== design/stab_delay_counter.sv
// stabilization delay counter: busy for exactly 4096 or 256 cycles after start
`timescale 1ns/1ps
module stab_delay_counter
    import opt_cfg_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic start,
    input  wire logic long_sel,
    // status
    output logic      busy,
    output logic      done
);

    logic [DLY_CNT_W-1:0] cnt_q;
    logic [DLY_CNT_W-1:0] cnt_d;
    logic                 busy_q;
    logic                 busy_d;
    logic                 done_q;
    logic                 done_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start && !busy_q)
        begin
            cnt_d  = long_sel ? DLY_CNT_W'(DLY_LONG_CYC - 1) : DLY_CNT_W'(DLY_SHORT_CYC - 1);
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            if (cnt_q == '0)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;

endmodule

// ===== tb/opt_cfg_props.sv
// assertion checker: decoded option outputs against the option byte inputs
`timescale 1ns/1ps
module opt_cfg_props
(
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // option bytes
    input wire logic [7:0] opt_byte1,
    input wire logic [7:0] opt_byte3,
    // decoded configuration
    input wire logic       cpu_hold,
    input wire logic       config_valid,
    input wire logic       long_reset_delay,
    input wire logic       rc_osc_enable,
    input wire logic [2:0] osc_current_range,
    input wire logic       range_low_power,
    input wire logic       range_medium_power,
    input wire logic       range_medium_speed,
    input wire logic       range_high_speed,
    input wire logic       ext_clock_select,
    input wire logic       pll_enable,
    input wire logic       pll_factor_eight,
    input wire logic       pll_halving_enable,
    input wire logic       package_32,
    input wire logic       package_44,
    input wire logic       package_48,
    input wire logic       triple_slave_enable
);
    logic [16:0] cfg;
    logic [12:0] hold_q;
    logic [12:0] hold_d;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // every decoded output in one word, so stability is one check
    assign cfg = {triple_slave_enable, package_48, package_44, package_32, pll_halving_enable,
                  pll_factor_eight, pll_enable, ext_clock_select, range_high_speed,
                  range_medium_speed, range_medium_power, range_low_power,
                  osc_current_range, rc_osc_enable, long_reset_delay};
    // cycles held since capture or halt exit; 13 bits cover the long delay
    always_comb
    begin
        hold_d = (cpu_hold && config_valid) ? hold_q + 13'h1 : 13'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_q <= 13'h0;
        else
            hold_q <= hold_d;
    end
    a_delay_select: assert property (config_valid |-> long_reset_delay == !opt_byte1[7])
        else $error("delay select wrong");
    a_hold_length: assert property ($fell(cpu_hold) && config_valid |->
        hold_q >= (long_reset_delay ? 13'hFFF : 13'hFF)
        && hold_q <= (long_reset_delay ? 13'h1003 : 13'h103))
        else $error("cpu hold length wrong");
    a_rc_select: assert property (config_valid |->
        rc_osc_enable == !opt_byte1[3] && osc_current_range == opt_byte1[6:4])
        else $error("rc select or range wrong");
    a_range_flags: assert property (config_valid |->
        {range_high_speed, range_medium_speed, range_medium_power, range_low_power}
        == ((opt_byte1[3] && !opt_byte1[6]) ? 4'h1 << opt_byte1[5:4] : 4'h0))
        else $error("range flags wrong");
    a_ext_clock: assert property (config_valid |->
        ext_clock_select == (opt_byte1[3] && opt_byte1[6:5] == 2'b11))
        else $error("external clock select wrong");
    a_pll_decode: assert property (config_valid |->
        pll_enable == !opt_byte1[0] && pll_factor_eight == opt_byte1[1]
        && pll_halving_enable == !opt_byte1[2])
        else $error("pll decode wrong");
    a_package_dec: assert property (config_valid |->
        {package_48, package_44, package_32}
        == (opt_byte3[7] ? 3'h4 : (opt_byte3[6] ? 3'h2 : 3'h1)))
        else $error("package decode wrong");
    a_triple_sel: assert property (config_valid |-> triple_slave_enable == !opt_byte3[5])
        else $error("triple slave select wrong");
    a_not_loaded: assert property (!config_valid |-> cfg == 17'h0)
        else $error("output active before capture");
    a_cfg_held: assert property (config_valid |=> config_valid && $stable(cfg))
        else $error("configuration changed after capture");
endmodule

bind option_byte_clock_config opt_cfg_props u_props
(
    .pclk, .presetn, .opt_byte1, .opt_byte3, .cpu_hold, .config_valid, .long_reset_delay,
    .rc_osc_enable, .osc_current_range, .range_low_power, .range_medium_power,
    .range_medium_speed, .range_high_speed, .ext_clock_select, .pll_enable,
    .pll_factor_eight, .pll_halving_enable, .package_32, .package_44, .package_48,
    .triple_slave_enable
);

// ===== tb/opt_prog_tool.sv
// programming tool model: burns option bytes 1..3 while the device is in programming mode
`timescale 1ns/1ps
module opt_prog_tool
(
    // high while the device is held in programming mode
    input  wire logic       prog_mode,
    // option bytes presented to the device
    output logic      [7:0] opt_byte1,
    output logic      [7:0] opt_byte2,
    output logic      [7:0] opt_byte3
);
    // erased array reads all ones
    initial
    begin
        opt_byte1 = 8'hFF;
        opt_byte2 = 8'hFF;
        opt_byte3 = 8'hFF;
    end
    // bad lets one scenario break the tool's own rules on purpose
    task automatic burn(input logic [7:0] b1, input logic [7:0] b3, input logic bad);
        logic [7:0] v;
        v = b1;
        if (prog_mode !== 1'b1)
            return;
        if (v[3] && !v[6])
            v[7] = 1'b0;
        if (!v[1] && !bad)
            v[2] = 1'b1;
        opt_byte1 <= v;
        opt_byte2 <= bad ? 8'h7E : 8'hFF;
        opt_byte3 <= {b3[7:5], bad ? 5'h0E : 5'h1F};
    endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module tb
    import opt_cfg_pkg::*;
;
    // clock, reset and apb
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // option bytes and decoded outputs
    logic [7:0]  b1, b2, b3;
    logic        cpu_hold, config_valid, long_reset_delay, rc_osc_enable;
    logic [2:0]  osc_current_range;
    logic        range_low_power, range_medium_power, range_medium_speed, range_high_speed;
    logic        ext_clock_select, pll_enable, pll_factor_eight, pll_halving_enable;
    logic        package_32, package_44, package_48, triple_slave_enable;
    logic [16:0] outs;
    // bookkeeping: read expectations as {pslverr, prdata}
    logic [32:0] expq[$];
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          seed;

    option_byte_clock_config dut
    (
        .pclk, .presetn, .opt_byte1(b1), .opt_byte2(b2), .opt_byte3(b3), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_hold, .config_valid,
        .long_reset_delay, .rc_osc_enable, .osc_current_range, .range_low_power,
        .range_medium_power, .range_medium_speed, .range_high_speed, .ext_clock_select,
        .pll_enable, .pll_factor_eight, .pll_halving_enable, .package_32, .package_44,
        .package_48, .triple_slave_enable
    );
    opt_prog_tool tool
    (
        .prog_mode(!presetn), .opt_byte1(b1), .opt_byte2(b2), .opt_byte3(b3)
    );
    // outputs packed in decode register order, triple slave on top
    assign outs = {triple_slave_enable, package_48, package_44, package_32, pll_halving_enable,
                   pll_factor_eight, pll_enable, ext_clock_select, range_high_speed,
                   range_medium_speed, range_medium_power, range_low_power,
                   osc_current_range, rc_osc_enable, long_reset_delay};

    function automatic logic [16:0] dec(input logic [7:0] a, input logic [7:0] c);
        logic [3:0] rng;
        rng = (a[3] && !a[6]) ? 4'h1 << a[5:4] : 4'h0;
        return {!c[5], c[7], c[7:6] == 2'b01, c[7:6] == 2'b00, !a[2], a[1], !a[0],
                a[3] && a[6:5] == 2'b11, rng, a[6:4], !a[3], !a[7]};
    endfunction

    task automatic check_val(input string what, input logic [32:0] exp, input logic [32:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the exact lag around the counter is the designer's, so allow a small window
    task automatic check_cnt(input string what, input int exp, input int got);
        compares++;
        if (got < exp - 2 || got > exp + 3)
        begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        expq.push_back(exp);
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic wait_while(input logic lvl, output int t);
        t = 0;
        while (cpu_hold === lvl && t < 5000)
        begin
            @(posedge pclk);
            t++;
        end
    endtask

    task automatic run_case(input int i);
        logic [7:0]  r1;
        logic [7:0]  r3;
        logic [16:0] e;
        int          t;
        int          n;
        presetn <= 1'b0;
        @(posedge pclk);
        r1 = 8'($random(seed));
        r3 = 8'($random(seed));
        r1[6:4] = i[2:0];
        r3[7:6] = i[1:0];
        tool.burn(r1, r3, i == 5);
        @(posedge pclk);
        presetn <= 1'b1;
        e = dec(b1, b3);
        n = b1[7] ? DLY_SHORT_CYC : DLY_LONG_CYC;
        rd(REG_DECODE, 33'h0);
        t = 0;
        while (config_valid !== 1'b1 && t < 20)
        begin
            @(posedge pclk);
            t++;
        end
        check_val("outputs", {16'h0, e}, {16'h0, outs});
        wait_while(1'b1, t);
        check_cnt("reset hold", n, t);
        rd(REG_RAW, {9'h0, b3, b2, b1});
        rd(REG_DECODE, {17'h0, e[15:0]});
        rd(REG_CTRL, 33'h0);
        rd(8'h10 + 8'(i * 4), {1'b1, 32'h0});
        rd(REG_STATUS, {29'h0, b2 != 8'hFF || b3[4:0] != 5'h1F,
                        !b1[2] && !b1[1] && !b1[0], 2'b10});
        // writes to the decode view must not disturb anything
        apb(REG_DECODE, 1'b1, 32'hFFFF_FFFF);
        apb(REG_CTRL, 1'b1, 32'h1);
        wait_while(1'b0, t);
        wait_while(1'b1, t);
        check_cnt("halt hold", n, t);
        check_val("outputs", {16'h0, e}, {16'h0, outs});
    endtask

    task automatic results;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // pair each completed read with the oldest expectation
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
            check_val("prdata", expq.pop_front(), {pslverr, prdata});

    // hang guard, above sixteen runs of the long delay (two per case)
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        seed = 32'hCF87317C;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 8; i++)
            run_case(i);
        results();
    end
endmodule
